// >>> rtl/fep_consts.vh
// Purpose: shared offsets, field positions, reset values and timing for the PHY core
// Assumes: 50 MHz system clock derived from the 25 MHz reference
// Notes: timer counts are derived from the times below by the core
`ifndef FEP_CONSTS_VH
`define FEP_CONSTS_VH

// Register byte addresses
`define FEP_ADDR_CTRL 8'h00
`define FEP_ADDR_ADV 8'h04
`define FEP_ADDR_STAT 8'h08
`define FEP_ADDR_SDCTL 8'h14

// Control register fields
`define FEP_CTRL_SPEED 13
`define FEP_CTRL_ANEG 12
`define FEP_CTRL_SLEEP 11
`define FEP_CTRL_DUPLEX 8

// Advertisement fields and reset value
`define FEP_ADV_100FD 8
`define FEP_ADV_10HD 5
`define FEP_ADV_RST 16'h01e1

// Signal-detect control fields
`define FEP_SD_AUTOSLEEP 0
`define FEP_SD_DELAY 1
`define FEP_SD_MDIXDIS 3

// Timing in printed units
`define FEP_CLK_KHZ 50000
`define FEP_JAB_MS 20
`define FEP_REC_MS 250
`define FEP_SQE_NS 1000
`define FEP_SDD_US 10

// Bit-enable dividers for 100 and 10 Mb/s line rates
`define FEP_DIV100 5'h01
`define FEP_DIV10 5'h13

// Line code groups, first transmitted bit in the msb
`define FEP_SYM_IDLE 5'h1f
`define FEP_SYM_J 5'h18
`define FEP_SYM_K 5'h11
`define FEP_SYM_T 5'h0d
`define FEP_SYM_R 5'h07

// Start-of-frame byte as it lands in the lsb-first shift window
`define FEP_SFD_REV 8'hab

`endif

// >>> rtl/fep_sync2.v
// Purpose: two-flop synchroniser for levels from outside the mclk domain
// Assumes: each bit is an independent, slowly changing level
// Notes: the first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module fep_sync2 #(
	parameter W = 1 // Number of bits
)(
	input wire mclk, // System clock
	input wire rst_n, // Async reset, active low
	input wire [W-1:0] asyncIn, // Raw inputs
	output wire [W-1:0] syncOut // Synchronised levels
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// Two stages give metastability a full cycle to settle
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end
		else
		begin
			meta_ff <= asyncIn;
			sync_ff <= meta_ff;
		end
	end

	assign syncOut = sync_ff;
endmodule // fep_sync2
`default_nettype wire

// >>> rtl/fep_scram.v
// Purpose: 11-bit stream scrambler, x^11 + x^9 + 1, used for both directions
// Assumes: en pulses once per line bit
// Notes: with load high the state trains from idle ones seen on the line
`timescale 1ns/100ps
`default_nettype none
module fep_scram (
	input wire mclk, // System clock
	input wire rst_n, // Async reset, active low
	input wire en, // One line bit
	input wire load, // Train state from received idle
	input wire dIn, // Bit in
	output wire dOut // Bit xor key
);
	reg [10:0] lfsr_ff;
	wire key;

	// Key stream tap; xor is its own inverse, so one block serves both ends
	assign key = lfsr_ff[10] ^ lfsr_ff[8];
	assign dOut = dIn ^ key;

	// Scrambled idle is the inverted key, so training shifts in ~dIn
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			lfsr_ff <= 11'h7ff;
		else if (en)
			lfsr_ff <= {lfsr_ff[9:0], load ? ~dIn : key};
	end
endmodule // fep_scram
`default_nettype wire

// >>> rtl/fep_core.v
// Purpose: digital core of a 10/100 twisted-pair transceiver
// Assumes: MAC logic runs on mclk; line and strap pins are asynchronous
// Notes: line bit rates are scaled to mclk enables; timers stay exact
`timescale 1ns/100ps
`default_nettype none
`include "fep_consts.vh"

// Functional notes
// [RL1] 100M transmit: nibbles to 4B/5B, scramble, NRZI, MLT3 serial symbols
// [RL2] 100M receive: clock from line edges, NRZI converted back to NRZ
// [RL3] Received stream descrambled, 5B decoded, then delivered as nibbles
// [RL4] Scrambling and descrambling happen only at 100M
// [RL5] 10M receive: Manchester split to clock and data, frames gated by squelch
// [RL6] 10M receive clock keeps running between frames
// [RL7] 10M: short test pulse on collision output after every sent frame
// [RL8] 10M: transmit enable high over 20 ms is jabber, transmitter off, COL high
// [RL9] Jabber clears after transmit enable low over 250 ms
// [RL10] Every clock derives from the single 25 MHz reference
// [RL11] Negotiation compares own and partner abilities, picks best common mode
// [RL12] Order: 100 full, 100 half, 10 full, 10 half
// [RL13] Partner not negotiating: speed from fixed signalling seen at receiver
// [RL14] Parallel detection takes duplex from control bit 8
// [RL15] Negotiation off: speed from control bit 13, duplex from bit 8
// [RL16] Large package loads speed and duplex bits from straps at reset
// [RL17] Small package defaults to 100M full duplex
// [RL18] Large package: negotiation from strap, then follows control bit 12
// [RL19] Small package: negotiation off unless RXD0 strap low
// [RL20] Controller sets signal-detect delay bit when deep standby needs it
// [RL21] Activity detect output; deep standby on its loss or on command
// [RL22] Detect and correct crossover cable unless disabled
// [RL23] Interrupt output flags status changes
// [RL24] Duplex strap is inverted before loading control bit 8
// [RL25] Speed strap loads speed bit and advertised 100M capability
// [RL26] Jabber timers count system clock cycles, not line activity
module fep_core #(
	parameter integer JAB_CYC = `FEP_JAB_MS * `FEP_CLK_KHZ, // Jabber limit in cycles
	parameter integer REC_CYC = `FEP_REC_MS * `FEP_CLK_KHZ // Jabber recovery in cycles
)(
	input wire mclk, // 50 MHz system clock
	input wire rst_n, // Async reset, active low
	input wire [7:0] regAddr, // Register byte address
	input wire [15:0] regWdata, // Register write data
	input wire regWr, // Write strobe
	input wire regRd, // Read strobe
	output reg [15:0] regRdata, // Read data, cycle after strobe
	input wire txEn, // MAC transmit enable
	input wire [3:0] txd, // MAC transmit nibble
	output wire txNibbleStb, // Nibble taken this cycle
	output reg rxDv, // Receive data valid
	output reg [3:0] rxd, // Receive nibble
	output reg rxEr, // Receive code error
	output wire rxClkEn, // Receive nibble clock enable
	output reg crs, // Carrier sense
	output reg col, // Collision, test pulse and jabber
	output reg [1:0] mlt3Out, // MLT3 level {minus, plus}
	output reg nrziOut, // NRZI line bit
	output reg manTxOut, // 10M Manchester half-bit
	output wire tx10Enable, // 10M transmitter enabled
	input wire rxLineClk, // Recovered line clock pin
	input wire rxLineData, // Line data pin
	input wire lineSquelchOk, // Line level above squelch
	input wire pairRxAct, // Energy on receive pair
	input wire pairTxAct, // Energy on transmit pair
	input wire pdSees100, // Fixed 100M signalling seen
	input wire strapSpeed, // Speed strap, high 100M
	input wire strapDuplex, // Duplex strap, low full
	input wire negotiationEnableStrap, // Negotiation strap
	input wire strapRxd0, // Small package negotiation strap
	input wire pkgSmall, // Small package tie
	input wire partnerNegotiates, // Partner sends advertisements
	input wire [3:0] partnerAbility, // Partner {100F,100H,10F,10H}
	output reg linkSpeed100, // Resolved speed
	output reg linkFullDuplex, // Resolved duplex
	output reg partnerActivityDetect, // Link partner active
	output reg deepSleep, // Deep standby request
	output reg mdixSwap, // Pairs swapped
	output reg intOut // Status change interrupt
);
	localparam integer SQE_I = `FEP_SQE_NS * `FEP_CLK_KHZ / 1000000;
	localparam integer SDD_I = `FEP_SDD_US * `FEP_CLK_KHZ / 1000;
	localparam [6:0] SQE_CYC = SQE_I[6:0];
	localparam [9:0] SDD_CYC = SDD_I[9:0];
	localparam [1:0] TX_IDLE = 2'h0;
	localparam [1:0] TX_K = 2'h1;
	localparam [1:0] TX_DATA = 2'h2;
	localparam [1:0] TX_R = 2'h3;
	localparam RX_HUNT = 1'b0;
	localparam RX_DATA = 1'b1;

	wire [5:0] lineS;
	wire [9:0] cfgS;
	reg [1:0] bootCnt_ff;
	reg ctrlSpeed_ff, ctrlDuplex_ff, ctrlAneg_ff, sleepCmd_ff;
	reg autoSleep_ff, sdDelay_ff, mdixDis_ff;
	reg [15:0] adv_ff;
	reg [3:0] common;
	reg nxtSpeed, nxtDuplex, nxtNoCommon, noCommon_ff;
	reg [4:0] divCnt_ff;
	reg [1:0] txSt_ff;
	reg [7:0] txSh_ff;
	reg [3:0] txCnt_ff;
	reg [1:0] mltPh_ff;
	reg jabber_ff, txEnP_ff;
	reg [23:0] jabCnt_ff;
	reg [6:0] sqeCnt_ff;
	reg rClkD_ff, rDatP_ff, rxSt_ff, rxLock_ff, rxStb_ff;
	reg [9:0] rxWin_ff;
	reg [2:0] rxCnt_ff;
	reg [9:0] sdCnt_ff;
	reg [6:0] statPrev_ff;
	reg [15:0] rdMux;
	wire sqS, pRxS, pTxS, pd100S, rClkS, rDatS;
	wire strapLoad, bitEn, unitEnd, txBit, scrOut, rxEdge, rxBit, descOut;
	wire [1:0] nxtPh;
	wire [6:0] statVec;
	wire [4:0] rxSym;
	wire [4:0] rxDec;

	// 4B/5B code group for a data nibble
	function [4:0] enc5;
		input [3:0] n;
		begin
			case (n)
			4'h0: enc5 = 5'h1e; 4'h1: enc5 = 5'h09; 4'h2: enc5 = 5'h14; 4'h3: enc5 = 5'h15;
			4'h4: enc5 = 5'h0a; 4'h5: enc5 = 5'h0b; 4'h6: enc5 = 5'h0e; 4'h7: enc5 = 5'h0f;
			4'h8: enc5 = 5'h12; 4'h9: enc5 = 5'h13; 4'ha: enc5 = 5'h16; 4'hb: enc5 = 5'h17;
			4'hc: enc5 = 5'h1a; 4'hd: enc5 = 5'h1b; 4'he: enc5 = 5'h1c; default: enc5 = 5'h1d;
			endcase
		end
	endfunction

	// Inverse table, msb flags a group that is not a data code
	function [4:0] dec5;
		input [4:0] s;
		begin
			case (s)
			5'h1e: dec5 = 5'h00; 5'h09: dec5 = 5'h01; 5'h14: dec5 = 5'h02; 5'h15: dec5 = 5'h03;
			5'h0a: dec5 = 5'h04; 5'h0b: dec5 = 5'h05; 5'h0e: dec5 = 5'h06; 5'h0f: dec5 = 5'h07;
			5'h12: dec5 = 5'h08; 5'h13: dec5 = 5'h09; 5'h16: dec5 = 5'h0a; 5'h17: dec5 = 5'h0b;
			5'h1a: dec5 = 5'h0c; 5'h1b: dec5 = 5'h0d; 5'h1c: dec5 = 5'h0e; 5'h1d: dec5 = 5'h0f;
			default: dec5 = 5'h1e;
			endcase
		end
	endfunction

	// Every pin from outside the mclk domain passes two flops
	fep_sync2 #(.W(6)) uLineSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn({lineSquelchOk, pairRxAct, pairTxAct, pdSees100, rxLineClk, rxLineData}),
		.syncOut(lineS)
	);
	fep_sync2 #(.W(10)) uCfgSync (
		.mclk(mclk),
		.rst_n(rst_n),
		.asyncIn({strapSpeed, strapDuplex, negotiationEnableStrap, strapRxd0, pkgSmall,
			partnerNegotiates, partnerAbility}),
		.syncOut(cfgS)
	);
	assign {sqS, pRxS, pTxS, pd100S, rClkS, rDatS} = lineS;

	// Straps are caught once the synchronisers have filled after release
	assign strapLoad = (bootCnt_ff == 2'h2);
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			bootCnt_ff <= 2'h0;
		else if (bootCnt_ff != 2'h3)
			bootCnt_ff <= bootCnt_ff + 2'h1;
	end

	// Control, advertisement and signal-detect registers
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrlSpeed_ff <= 1'b1;
			ctrlDuplex_ff <= 1'b1;
			ctrlAneg_ff <= 1'b0;
			sleepCmd_ff <= 1'b0;
			adv_ff <= `FEP_ADV_RST;
			autoSleep_ff <= 1'b0;
			sdDelay_ff <= 1'b0;
			mdixDis_ff <= 1'b0;
		end
		else if (strapLoad)
		begin
			if (cfgS[5])
			begin
				ctrlSpeed_ff <= 1'b1; // RL17
				ctrlDuplex_ff <= 1'b1; // RL17
				ctrlAneg_ff <= ~cfgS[6]; // RL19
			end
			else
			begin
				ctrlSpeed_ff <= cfgS[9]; // RL16 RL25
				ctrlDuplex_ff <= ~cfgS[8]; // RL16 RL24
				ctrlAneg_ff <= cfgS[7]; // RL18
				adv_ff[8:7] <= {2{cfgS[9]}}; // RL25
			end
		end
		else if (regWr)
		begin
			case (regAddr)
			`FEP_ADDR_CTRL:
			begin
				ctrlSpeed_ff <= regWdata[`FEP_CTRL_SPEED]; // RL15
				ctrlAneg_ff <= regWdata[`FEP_CTRL_ANEG]; // RL18
				sleepCmd_ff <= regWdata[`FEP_CTRL_SLEEP]; // RL21
				ctrlDuplex_ff <= regWdata[`FEP_CTRL_DUPLEX]; // RL15
			end
			`FEP_ADDR_ADV: adv_ff <= regWdata;
			`FEP_ADDR_SDCTL:
			begin
				autoSleep_ff <= regWdata[`FEP_SD_AUTOSLEEP];
				sdDelay_ff <= regWdata[`FEP_SD_DELAY];
				mdixDis_ff <= regWdata[`FEP_SD_MDIXDIS];
			end
			default: ;
			endcase
		end
	end

	// Mode resolution from negotiation, parallel detection or forced bits
	always @*
	begin
		common = adv_ff[`FEP_ADV_100FD:`FEP_ADV_10HD] & cfgS[3:0]; // RL11
		nxtNoCommon = 1'b0;
		nxtSpeed = ctrlSpeed_ff; // RL15
		nxtDuplex = ctrlDuplex_ff; // RL15
		if (ctrlAneg_ff && cfgS[4])
		begin
			nxtSpeed = common[3] | common[2]; // RL12
			nxtDuplex = common[3] | (~common[2] & common[1]); // RL12
			nxtNoCommon = ~|common;
		end
		else if (ctrlAneg_ff)
		begin
			nxtSpeed = pd100S; // RL13
			nxtDuplex = ctrlDuplex_ff; // RL14
		end
	end

	// Line bit enable from one divider off the reference-derived clock
	assign bitEn = (divCnt_ff == 5'h00);
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			divCnt_ff <= 5'h00;
			linkSpeed100 <= 1'b0;
			linkFullDuplex <= 1'b0;
			noCommon_ff <= 1'b0;
		end
		else
		begin
			divCnt_ff <= bitEn ? (linkSpeed100 ? `FEP_DIV100 : `FEP_DIV10) : divCnt_ff - 5'h01; // RL10
			linkSpeed100 <= nxtSpeed;
			linkFullDuplex <= nxtDuplex;
			noCommon_ff <= nxtNoCommon;
		end
	end

	// Unit boundary: a 5-bit group at 100M or a nibble of half-bits at 10M
	assign unitEnd = bitEn && (txCnt_ff <= 4'h1);
	assign txNibbleStb = unitEnd && txEn &&
		(linkSpeed100 ? (txSt_ff == TX_DATA) : ~jabber_ff);
	assign txBit = txSh_ff[4];
	assign tx10Enable = ~jabber_ff; // RL8
	assign nxtPh = mltPh_ff + {1'b0, scrOut};

	fep_scram uTxScr (
		.mclk(mclk),
		.rst_n(rst_n),
		.en(bitEn & linkSpeed100), // RL4
		.load(1'b0),
		.dIn(txBit),
		.dOut(scrOut)
	);

	// Transmit sequencer and line coders
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txSt_ff <= TX_IDLE;
			txSh_ff <= 8'h1f;
			txCnt_ff <= 4'h0;
			mltPh_ff <= 2'h0;
			mlt3Out <= 2'h0;
			nrziOut <= 1'b0;
			manTxOut <= 1'b0;
		end
		else if (bitEn)
		begin
			if (linkSpeed100)
			begin
				nrziOut <= nrziOut ^ scrOut; // RL1
				mltPh_ff <= nxtPh; // RL1
				mlt3Out <= (nxtPh == 2'h1) ? 2'h1 : ((nxtPh == 2'h3) ? 2'h2 : 2'h0); // RL1
			end
			// Half-bits: inverted value first, true value second
			manTxOut <= ~linkSpeed100 && (txSt_ff == TX_DATA) &&
				(txCnt_ff[0] ? txSh_ff[0] : ~txSh_ff[0]);
			if (unitEnd && linkSpeed100)
			begin
				txCnt_ff <= 4'h5;
				case (txSt_ff)
				TX_IDLE:
				begin
					txSh_ff <= {3'h0, txEn ? `FEP_SYM_J : `FEP_SYM_IDLE}; // RL1
					txSt_ff <= txEn ? TX_K : TX_IDLE;
				end
				TX_K:
				begin
					txSh_ff <= {3'h0, `FEP_SYM_K};
					txSt_ff <= TX_DATA;
				end
				TX_DATA:
				begin
					txSh_ff <= {3'h0, txEn ? enc5(txd) : `FEP_SYM_T}; // RL1
					txSt_ff <= txEn ? TX_DATA : TX_R;
				end
				TX_R:
				begin
					txSh_ff <= {3'h0, `FEP_SYM_R};
					txSt_ff <= TX_IDLE;
				end
				default: txSt_ff <= TX_IDLE;
				endcase
			end
			else if (unitEnd)
			begin
				txCnt_ff <= 4'h8;
				txSh_ff <= txNibbleStb ? {4'h0, txd} : 8'h00;
				txSt_ff <= txNibbleStb ? TX_DATA : TX_IDLE;
			end
			else
			begin
				txCnt_ff <= txCnt_ff - 4'h1;
				if (linkSpeed100)
					txSh_ff <= {txSh_ff[6:0], 1'b1};
				else if (txCnt_ff[0])
					txSh_ff <= {1'b0, txSh_ff[7:1]};
			end
		end
	end

	// Jabber watchdog and frame-end test pulse; counts are cycles of mclk
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			jabber_ff <= 1'b0;
			jabCnt_ff <= 24'h000000;
			txEnP_ff <= 1'b0;
			sqeCnt_ff <= 7'h00;
			col <= 1'b0;
		end
		else
		begin
			txEnP_ff <= txEn;
			if (linkSpeed100 || (txEn == jabber_ff))
				jabCnt_ff <= 24'h000000;
			else if (!jabber_ff && jabCnt_ff >= JAB_CYC[23:0])
			begin
				jabber_ff <= 1'b1; // RL8 RL26
				jabCnt_ff <= 24'h000000;
			end
			else if (jabber_ff && jabCnt_ff >= REC_CYC[23:0])
			begin
				jabber_ff <= 1'b0; // RL9 RL26
				jabCnt_ff <= 24'h000000;
			end
			else
				jabCnt_ff <= jabCnt_ff + 24'h000001;
			if (txEnP_ff && !txEn && !linkSpeed100 && !jabber_ff)
				sqeCnt_ff <= SQE_CYC; // RL7
			else if (sqeCnt_ff != 7'h00)
				sqeCnt_ff <= sqeCnt_ff - 7'h01;
			col <= jabber_ff || (sqeCnt_ff != 7'h00); // RL7 RL8 RL9
		end
	end

	// Recovered clock edge; descrambler trains until ten idle ones are seen
	assign rxEdge = rClkS & ~rClkD_ff; // RL2 RL5
	assign rxBit = linkSpeed100 ? descOut : rDatS; // RL4
	assign rxSym = {rxWin_ff[3:0], rxBit};
	assign rxDec = dec5(rxSym);
	fep_scram uRxScr (
		.mclk(mclk),
		.rst_n(rst_n),
		.en(rxEdge & linkSpeed100), // RL4
		.load(~rxLock_ff),
		.dIn(rDatS ^ rDatP_ff), // RL2
		.dOut(descOut) // RL3
	);

	// Receive framing, decoding and nibble assembly
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rClkD_ff <= 1'b0;
			rDatP_ff <= 1'b0;
			rxWin_ff <= 10'h000;
			rxSt_ff <= RX_HUNT;
			rxLock_ff <= 1'b0;
			rxCnt_ff <= 3'h0;
			rxStb_ff <= 1'b0;
			rxDv <= 1'b0;
			rxd <= 4'h0;
			rxEr <= 1'b0;
		end
		else
		begin
			rClkD_ff <= rClkS;
			rxStb_ff <= 1'b0;
			if (!sqS || (!linkSpeed100 && rxLock_ff))
			begin
				rxLock_ff <= 1'b0;
				rxSt_ff <= RX_HUNT; // RL5
				rxDv <= 1'b0;
			end
			else if (rxEdge)
			begin
				rDatP_ff <= rDatS;
				rxWin_ff <= {rxWin_ff[8:0], rxBit};
				if (linkSpeed100 && &rxWin_ff)
					rxLock_ff <= 1'b1;
				rxCnt_ff <= rxCnt_ff + 3'h1;
				if (rxSt_ff == RX_HUNT)
				begin
					if (linkSpeed100 ? (rxLock_ff && {rxWin_ff[8:0], rxBit} == {`FEP_SYM_J, `FEP_SYM_K})
						: ({rxWin_ff[6:0], rxBit} == `FEP_SFD_REV))
					begin
						rxSt_ff <= RX_DATA;
						rxCnt_ff <= 3'h0;
						rxDv <= ~linkSpeed100;
						rxd <= 4'hd;
						rxStb_ff <= ~linkSpeed100;
					end
				end
				else if (linkSpeed100 && rxCnt_ff == 3'h4)
				begin
					rxCnt_ff <= 3'h0;
					if (rxSym == `FEP_SYM_T || rxSym == `FEP_SYM_IDLE)
					begin
						rxSt_ff <= RX_HUNT;
						rxDv <= 1'b0;
					end
					else
					begin
						rxd <= rxDec[3:0]; // RL3
						rxEr <= rxDec[4];
						rxDv <= 1'b1;
						rxStb_ff <= 1'b1; // RL3
					end
				end
				else if (!linkSpeed100 && rxCnt_ff == 3'h3)
				begin
					rxCnt_ff <= 3'h0;
					rxd <= {rxBit, rxWin_ff[0], rxWin_ff[1], rxWin_ff[2]}; // RL5
					rxEr <= 1'b0;
					rxStb_ff <= 1'b1;
				end
			end
		end
	end

	// Between frames the nibble clock falls back to the local divider
	assign rxClkEn = (rxSt_ff == RX_DATA) ? rxStb_ff : unitEnd; // RL6

	// Activity detect, standby, crossover, carrier and status change
	assign statVec = {deepSleep, noCommon_ff, jabber_ff, mdixSwap, partnerActivityDetect,
		linkFullDuplex, linkSpeed100};
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sdCnt_ff <= 10'h000;
			partnerActivityDetect <= 1'b0;
			deepSleep <= 1'b0;
			mdixSwap <= 1'b0;
			crs <= 1'b0;
			statPrev_ff <= 7'h00;
			intOut <= 1'b0;
		end
		else
		begin
			if (!sqS)
			begin
				sdCnt_ff <= 10'h000;
				partnerActivityDetect <= 1'b0; // RL21
			end
			else if (!sdDelay_ff || sdCnt_ff == SDD_CYC)
				partnerActivityDetect <= 1'b1; // RL20 RL21
			else
				sdCnt_ff <= sdCnt_ff + 10'h001;
			deepSleep <= sleepCmd_ff || (autoSleep_ff && !partnerActivityDetect); // RL21
			if (mdixDis_ff)
				mdixSwap <= 1'b0; // RL22
			else if (pTxS && !pRxS)
				mdixSwap <= 1'b1; // RL22
			else if (pRxS && !pTxS)
				mdixSwap <= 1'b0; // RL22
			crs <= rxDv || (!linkFullDuplex && txSt_ff != TX_IDLE) || (!linkSpeed100 && txEn);
			statPrev_ff <= statVec;
			if (statVec != statPrev_ff)
				intOut <= 1'b1; // RL23
			else if (regRd && regAddr == `FEP_ADDR_STAT)
				intOut <= 1'b0;
		end
	end

	// Read mux; unmapped addresses read zero
	always @*
	begin
		rdMux = 16'h0000;
		case (regAddr)
		`FEP_ADDR_CTRL:
		begin
			rdMux[`FEP_CTRL_SPEED] = ctrlSpeed_ff;
			rdMux[`FEP_CTRL_ANEG] = ctrlAneg_ff;
			rdMux[`FEP_CTRL_SLEEP] = sleepCmd_ff;
			rdMux[`FEP_CTRL_DUPLEX] = ctrlDuplex_ff;
		end
		`FEP_ADDR_ADV: rdMux = adv_ff;
		`FEP_ADDR_STAT: rdMux = {9'h000, statVec};
		`FEP_ADDR_SDCTL:
		begin
			rdMux[`FEP_SD_AUTOSLEEP] = autoSleep_ff;
			rdMux[`FEP_SD_DELAY] = sdDelay_ff;
			rdMux[`FEP_SD_MDIXDIS] = mdixDis_ff;
		end
		default: rdMux = 16'h0000;
		endcase
	end

	// Read data stands for exactly the cycle after the strobe
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			regRdata <= 16'h0000;
		else
			regRdata <= regRd ? rdMux : 16'h0000;
	end
endmodule // fep_core
`default_nettype wire

// >>> tb/fep_core_asserts.sv
// Purpose: port-level checks for the PHY core
// Assumes: jabber limits handed on from the core parameters
// Notes: run counters give the long timing checks exact bounds
`timescale 1ns/100ps
`default_nettype none
module fep_core_asserts #(
	parameter integer JAB_CYC = 200, // Jabber limit
	parameter integer REC_CYC = 400 // Recovery limit
)(
	input wire logic mclk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic regRd, // Read strobe
	input wire logic [15:0] regRdata, // Read data
	input wire logic txEn, // Transmit enable
	input wire logic txNibbleStb, // Nibble taken
	input wire logic rxClkEn, // Receive nibble tick
	input wire logic col, // Collision
	input wire logic [1:0] mlt3Out, // Line levels
	input wire logic tx10Enable, // 10M transmitter on
	input wire logic linkSpeed100 // Resolved speed
);
	int hiRun_ff, loRun_ff, gap_ff;
	// Enable run lengths; a long gap in ticks means a stalled receive clock
	always @(posedge mclk or negedge rst_n)
		if (!rst_n)
		begin
			hiRun_ff <= 0;
			loRun_ff <= 0;
			gap_ff <= 0;
		end
		else
		begin
			hiRun_ff <= txEn ? hiRun_ff + 1 : 0;
			loRun_ff <= txEn ? 0 : loRun_ff + 1;
			gap_ff <= rxClkEn ? 0 : gap_ff + 1;
		end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_mlt3_legal: assert property (mlt3Out != 2'b11) else $error("mlt3 both");
	a_read_once: assert property (!$past(regRd) |-> regRdata == 16'h0) else $error("stale rd");
	a_jab_col: assert property (!tx10Enable |=> col) else $error("jab col");
	a_jab_nostb: assert property (!tx10Enable && !linkSpeed100 |-> !txNibbleStb)
		else $error("jab stb");
	a_jab_time: assert property ($fell(tx10Enable) |-> hiRun_ff >= JAB_CYC
		&& hiRun_ff <= JAB_CYC + 4) else $error("jab time");
	a_rec_time: assert property ($rose(tx10Enable) && $past(col)
		|-> loRun_ff >= REC_CYC && loRun_ff <= REC_CYC + 4) else $error("rec time");
	a_sqe_pulse: assert property ($rose(col) && tx10Enable |-> col [*8] ##[41:43] !col)
		else $error("sqe width");
	a_rx_tick: assert property (!linkSpeed100 |-> gap_ff < 400) else $error("rx tick");
	c_jab: cover property ($fell(tx10Enable));
	c_sqe: cover property ($rose(col) && tx10Enable);
	c_read: cover property (regRd ##1 regRdata != 16'h0);
endmodule // fep_core_asserts
bind fep_core fep_core_asserts #(.JAB_CYC(JAB_CYC), .REC_CYC(REC_CYC)) u_fep_core_asserts (
	.mclk, .rst_n, .regRd, .regRdata, .txEn, .txNibbleStb, .rxClkEn, .col, .mlt3Out,
	.tx10Enable, .linkSpeed100);
`default_nettype wire

// >>> tb/fep_mac.sv
// Purpose: MAC model on the nibble transmit port
// Assumes: txNibbleStb marks the edge that takes txd
// Notes: gives up on a nibble after 400 cycles, like a stuck MAC
`timescale 1ns/100ps
`default_nettype none
module fep_mac (
	input wire logic mclk, // System clock
	input wire logic go, // Start a frame
	input wire logic [7:0] len, // Nibbles to send
	input wire logic txNibbleStb, // Nibble taken
	output var logic txEn, // Transmit enable
	output var logic [3:0] txd, // Transmit nibble
	output var logic busy // Frame running
);
	initial
	begin
		txEn = 0;
		txd = 0;
		busy = 0;
	end
	// One frame a start pulse; txd held until the taking edge
	always @(posedge go)
	begin : frame
		int w;
		busy = 1;
		@(posedge mclk);
		txEn <= 1;
		txd <= 4'h5;
		for (int i = 1; i <= len; i++)
		begin
			w = 0;
			do
			begin
				@(posedge mclk);
				w++;
			end
			while (!txNibbleStb && w < 400);
			txd <= i[3:0];
		end
		txEn <= 0;
		busy = 0;
	end
endmodule // fep_mac
`default_nettype wire

// >>> tb/fast_ethernet_phy_pcs_negotiation_test.sv
// Purpose: self-checking bench for the PHY core
// Assumes: large package straps, short jabber timers
// Notes: link clock toggles only in t_rx10, also for the byte sent on a quiet line
`timescale 1ns/100ps
`default_nettype none
module fast_ethernet_phy_pcs_negotiation_test;
	localparam int JAB = 200;
	localparam int REC = 400;
	logic mclk = 0, rst_n = 0, regWr = 0, regRd = 0, go = 0;
	logic [7:0] regAddr = 0, len = 0;
	logic [15:0] regWdata = 0;
	logic rxLineClk = 0, rxLineData = 0, lineSquelchOk = 0, pairRxAct = 0, pairTxAct = 0;
	logic pdSees100 = 0, partnerNegotiates = 0;
	logic [3:0] partnerAbility = 0;
	wire [15:0] regRdata;
	wire [3:0] txd, rxd;
	wire txEn, txNibbleStb, rxDv, rxClkEn, col, tx10Enable, busy, linkSpeed100;
	wire linkFullDuplex, partnerActivityDetect, deepSleep, mdixSwap, intOut;
	int err_count = 0, samples_checked = 0;
	fep_core #(.JAB_CYC(JAB), .REC_CYC(REC)) u_fep_core (.mclk, .rst_n, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .txEn, .txd, .txNibbleStb, .rxDv, .rxd, .rxEr(), .rxClkEn,
		.crs(), .col, .mlt3Out(), .nrziOut(), .manTxOut(), .tx10Enable, .rxLineClk, .rxLineData,
		.lineSquelchOk, .pairRxAct, .pairTxAct, .pdSees100, .strapSpeed(1'b1), .strapDuplex(1'b0),
		.negotiationEnableStrap(1'b0), .strapRxd0(1'b1), .pkgSmall(1'b0), .partnerNegotiates,
		.partnerAbility, .linkSpeed100, .linkFullDuplex, .partnerActivityDetect, .deepSleep,
		.mdixSwap, .intOut);
	fep_mac u_fep_mac (.mclk, .go, .len, .txNibbleStb, .txEn, .txd, .busy);
	always #10 mclk = ~mclk;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1;
		@(posedge mclk);
		regWr <= 0;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [15:0] e);
		regAddr <= a;
		regRd <= 1;
		@(posedge mclk);
		regRd <= 0;
		@(posedge mclk);
		chk(regRdata, e);
	endtask
	task automatic lnk(input logic [1:0] e);
		repeat (8) @(posedge mclk);
		chk({14'h0, linkSpeed100, linkFullDuplex}, {14'h0, e});
	endtask
	task automatic send(input logic [7:0] n);
		len <= n;
		go <= 1;
		@(posedge mclk);
		go <= 0;
		while (busy) @(posedge mclk);
	endtask
	// One line bit, sampled on the rising link clock
	task automatic lbit(input logic b);
		rxLineData <= b;
		repeat (4) @(posedge mclk);
		rxLineClk <= 1;
		repeat (4) @(posedge mclk);
		rxLineClk <= 0;
	endtask
	task automatic lbyte(input logic [7:0] v);
		for (int i = 0; i < 8; i++) lbit(v[i]);
	endtask
	// Straps land at reset; unmapped reads give zero
	task automatic t_strap;
		rdck(8'h00, 16'h2100);
		rdck(8'h04, 16'h01e1);
		chk({15'h0, intOut}, 16'h1);
		rdck(8'h08, 16'h0003);
		chk({15'h0, intOut}, 16'h0);
		rdck(8'h10, 16'h0000);
		lnk(2'b11);
	endtask
	// Forced modes follow control bits
	task automatic t_force;
		wr(8'h00, 16'h0100);
		lnk(2'b01);
		wr(8'h00, 16'h2000);
		lnk(2'b10);
		wr(8'h00, 16'h0000);
		lnk(2'b00);
	endtask
	// Short 10M frame ends with a test pulse
	task automatic t_sqe;
		send(8'd1);
		repeat (5) @(posedge mclk);
		chk({15'h0, col}, 16'h1);
		repeat (60) @(posedge mclk);
		chk({15'h0, col}, 16'h0);
	endtask
	// Overlong enable trips jabber; recovery only after the full quiet time
	task automatic t_jab;
		send(8'd4);
		chk({14'h0, col, tx10Enable}, 16'h2);
		repeat (REC - 20) @(posedge mclk);
		chk({14'h0, col, tx10Enable}, 16'h2);
		repeat (40) @(posedge mclk);
		chk({14'h0, col, tx10Enable}, 16'h1);
	endtask
	// Best common mode, then parallel detection
	task automatic t_neg;
		logic [3:0] ab [5] = '{4'ha, 4'h6, 4'h3, 4'h1, 4'h0};
		logic [1:0] ex [5] = '{2'b11, 2'b10, 2'b01, 2'b00, 2'b00};
		wr(8'h00, 16'h1000);
		partnerNegotiates <= 1;
		for (int i = 0; i < 5; i++)
		begin
			partnerAbility <= ab[i];
			lnk(ex[i]);
		end
		wr(8'h04, 16'h0041);
		partnerAbility <= 4'hf;
		lnk(2'b01);
		partnerNegotiates <= 0;
		pdSees100 <= 1;
		lnk(2'b10);
		wr(8'h00, 16'h1100);
		pdSees100 <= 0;
		lnk(2'b01);
	endtask
	// Crossover pick, activity and auto standby
	task automatic t_pair;
		pairTxAct <= 1;
		lineSquelchOk <= 1;
		repeat (8) @(posedge mclk);
		chk({14'h0, mdixSwap, partnerActivityDetect}, 16'h3);
		pairTxAct <= 0;
		pairRxAct <= 1;
		lineSquelchOk <= 0;
		wr(8'h14, 16'h0003);
		repeat (8) @(posedge mclk);
		chk({14'h0, mdixSwap, deepSleep}, 16'h1);
		wr(8'h14, 16'h0000);
	endtask
	// Quiet line ignored; frame decoded after the start byte
	task automatic t_rx10;
		lbyte(8'hd5);
		chk({15'h0, rxDv}, 16'h0);
		lineSquelchOk <= 1;
		lbyte(8'h55);
		lbyte(8'hd5);
		repeat (4) @(posedge mclk);
		chk({11'h0, rxDv, rxd}, 16'h1d);
		for (int i = 0; i < 4; i++) lbit(i < 2);
		repeat (4) @(posedge mclk);
		chk({11'h0, rxDv, rxd}, 16'h13);
		lineSquelchOk <= 0;
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (3) @(posedge mclk);
		rst_n <= 1;
		repeat (10) @(posedge mclk);
		t_strap;
		t_force;
		t_sqe;
		t_jab;
		t_neg;
		t_pair;
		t_rx10;
		final_report;
	end
	// Watchdog well past the expected run
	initial
	begin
		#200000;
		err_count++;
		final_report;
	end
endmodule // fast_ethernet_phy_pcs_negotiation_test
`default_nettype wire
